// [rtl/ipg_glue.sv]
/*
 Drive-port glue: transceiver enables, drive selects and bit-7 steering.
 Every output comes from the state register, so pins never glitch while decode settles.
 Assumes decode selects, strobes and address arrive from outside asynchronously;
 the external bidirectional wires are resolved by the board from the enables.
*/
// Operation
// - drive high-byte transceiver enable low for the upper data byte.
// - drive low-byte transceiver enable low for the lower data byte.
// - both byte enables go with the task-register select on 16-bit transfers.
// - on a decoded write, drive bit 7 pin outputs host data bit 7.
// - on a decoded read not at 3F7H, drive bit 7 feeds host bit 7.
// - on a read of 3F7H, host bit 7 shows the disk-change status.
// - aux-register select asserts together with low-byte enable.
// - task select asserts with low enable, or both enables when 16-bit.
// - two separate drive selects, each from the external decode inputs qualified by a read or write strobe.
`timescale 1ns/10ps
module ipg_glue (
    input wire logic clk,
    input wire logic rst,
    input wire logic decode_task_hit,
    input wire logic decode_aux_hit,
    input wire logic xfer_16bit,
    input wire logic ior_n,
    input wire logic iow_n,
    input wire logic [9:0] host_addr,
    input wire logic host_data_bit7_in,
    input wire logic drive_bit7_io_in,
    input wire logic floppy_disk_changed_n,
    output logic hi_byte_xcvr_en_n,
    output logic lo_byte_xcvr_en_n,
    output logic drive_task_regs_sel,
    output logic drive_aux_regs_sel,
    output logic drive_bit7_io_out,
    output logic drive_bit7_io_oe,
    output logic host_data_bit7_out,
    output logic host_data_bit7_oe
);
    import ipg_pkg::*;

    ipg_sync_if sif ();
    ipg_sync u_sync (
        .clk(clk),
        .rst(rst),
        .raw({decode_task_hit, decode_aux_hit, xfer_16bit, ~ior_n, ~iow_n,
              host_data_bit7_in, drive_bit7_io_in, floppy_disk_changed_n}),
        .out(sif)
    );

    logic s_task;
    logic s_aux;
    logic s_wide;
    logic s_rd;
    logic s_wr;
    logic s_hd7;
    logic s_dd7;
    logic s_floppy_disk_changed_n_n;
    logic [9:0] addr_s2;

    assign {s_task, s_aux, s_wide, s_rd, s_wr, s_hd7, s_dd7, s_floppy_disk_changed_n_n} = sif.bits;

    ipg_state_t st_r;
    ipg_state_t st_nxt;
    logic hit;

    assign addr_s2 = st_r.addr_sync;

    always_comb begin
        hit = s_task | s_aux;
        st_nxt = st_r;
        st_nxt.mode = IPG_IDLE;
        st_nxt.hi_en_n = 1'b1;
        st_nxt.lo_en_n = 1'b1;
        st_nxt.task_sel = 1'b0;
        st_nxt.aux_sel = 1'b0;
        st_nxt.d7_oe = 1'b0;
        st_nxt.host_d7_oe = 1'b0;
        // address rides the same two stages as the strobes so the 3F7H compare lines up
        st_nxt.addr_meta = host_addr;
        st_nxt.addr_sync = st_r.addr_meta;
        // a strobe alone selects nothing: selects come only from decode
        if (hit && (s_rd || s_wr)) begin
            st_nxt.lo_en_n = 1'b0;
            // a double hit goes to the task registers, the only path that can be 16 bits
            if (s_task) begin
                st_nxt.task_sel = 1'b1;
                st_nxt.hi_en_n = ~s_wide;
            end else begin
                st_nxt.aux_sel = 1'b1;
            end
            // write wins if both strobes appear, avoiding two drivers on bit 7
            if (s_wr) begin
                st_nxt.mode = IPG_WR;
                st_nxt.d7_oe = 1'b1;
                st_nxt.d7_out = s_hd7;
            end else if (addr_s2 == IPG_FLOPPY_DISK_CHANGED_N_ADDR) begin
                st_nxt.mode = IPG_RD_FLOPPY_DISK_CHANGED_N;
                st_nxt.host_d7_oe = 1'b1;
                st_nxt.host_d7 = s_floppy_disk_changed_n_n;
            end else begin
                st_nxt.mode = IPG_RD;
                st_nxt.host_d7_oe = 1'b1;
                st_nxt.host_d7 = s_dd7;
            end
        end
        case (st_nxt.mode)
            IPG_IDLE: st_nxt.d7_oe = 1'b0;
            IPG_WR: st_nxt.d7_oe = 1'b1;
            IPG_RD, IPG_RD_FLOPPY_DISK_CHANGED_N: st_nxt.d7_oe = 1'b0;
            default: st_nxt.d7_oe = 1'b0;
        endcase
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            st_r <= '{mode: IPG_IDLE, hi_en_n: 1'b1, lo_en_n: 1'b1, task_sel: 1'b0,
                      aux_sel: 1'b0, d7_oe: 1'b0, d7_out: 1'b0, host_d7: 1'b0,
                      host_d7_oe: 1'b0, addr_meta: 10'h000, addr_sync: 10'h000};
        end else begin
            st_r <= st_nxt;
        end
    end

    assign hi_byte_xcvr_en_n = st_r.hi_en_n;
    assign lo_byte_xcvr_en_n = st_r.lo_en_n;
    assign drive_task_regs_sel = st_r.task_sel;
    assign drive_aux_regs_sel = st_r.aux_sel;
    assign drive_bit7_io_out = st_r.d7_out;
    assign drive_bit7_io_oe = st_r.d7_oe;
    assign host_data_bit7_out = st_r.host_d7;
    assign host_data_bit7_oe = st_r.host_d7_oe;

    hi_needs_task_a: assert property (@(posedge clk) disable iff (rst)
        !hi_byte_xcvr_en_n |-> drive_task_regs_sel && !lo_byte_xcvr_en_n)
        else $error("high enable without task select and low enable");
    aux_with_lo_a: assert property (@(posedge clk) disable iff (rst)
        drive_aux_regs_sel |-> !lo_byte_xcvr_en_n && hi_byte_xcvr_en_n)
        else $error("aux select without low enable only");
    sel_exclusive_a: assert property (@(posedge clk) disable iff (rst)
        !(drive_task_regs_sel && drive_aux_regs_sel))
        else $error("both drive selects active");
    task_lo_a: assert property (@(posedge clk) disable iff (rst)
        drive_task_regs_sel |-> !lo_byte_xcvr_en_n)
        else $error("task select without low enable");
    lo_has_sel_a: assert property (@(posedge clk) disable iff (rst)
        !lo_byte_xcvr_en_n |-> drive_task_regs_sel || drive_aux_regs_sel)
        else $error("low enable without a select");
    write_drives_a: assert property (@(posedge clk) disable iff (rst)
        (s_wr && hit) |=> drive_bit7_io_oe && drive_bit7_io_out == $past(s_hd7))
        else $error("write did not drive bit 7");
    read_pass_a: assert property (@(posedge clk) disable iff (rst)
        (s_rd && !s_wr && hit && addr_s2 != IPG_FLOPPY_DISK_CHANGED_N_ADDR)
        |=> host_data_bit7_oe && host_data_bit7_out == $past(s_dd7))
        else $error("read did not pass drive bit 7");
    read_floppy_disk_changed_n_a: assert property (@(posedge clk) disable iff (rst)
        (s_rd && !s_wr && hit && addr_s2 == IPG_FLOPPY_DISK_CHANGED_N_ADDR)
        |=> host_data_bit7_out == $past(s_floppy_disk_changed_n_n))
        else $error("3F7 read did not show disk change");
    idle_quiet_a: assert property (@(posedge clk) disable iff (rst)
        !(hit && (s_rd || s_wr)) |=> lo_byte_xcvr_en_n && hi_byte_xcvr_en_n
        && !drive_bit7_io_oe && !drive_task_regs_sel && !drive_aux_regs_sel)
        else $error("outputs active with no access");
    hi_from_wide_a: assert property (@(posedge clk) disable iff (rst)
        (s_task && s_wide && (s_rd || s_wr)) |=> !hi_byte_xcvr_en_n)
        else $error("16-bit task access missed high enable");

    // pairing of enables and selects, seen from the decoded request
    narrow_no_hi_a: assert property (@(posedge clk) disable iff (rst)
        (s_task && !s_wide && (s_rd || s_wr)) |=> hi_byte_xcvr_en_n)
        else $error("narrow task access raised high enable");
    aux_lo_only_a: assert property (@(posedge clk) disable iff (rst)
        (s_aux && !s_task && (s_rd || s_wr))
        |=> drive_aux_regs_sel && !lo_byte_xcvr_en_n && hi_byte_xcvr_en_n)
        else $error("aux access without aux select and low enable");
    task_sel_hit_a: assert property (@(posedge clk) disable iff (rst)
        (s_task && (s_rd || s_wr)) |=> drive_task_regs_sel)
        else $error("task access without task select");
    lo_follows_hit_a: assert property (@(posedge clk) disable iff (rst)
        (hit && (s_rd || s_wr)) |=> !lo_byte_xcvr_en_n)
        else $error("decoded access without low enable");
    task_wins_a: assert property (@(posedge clk) disable iff (rst)
        (s_task && s_aux && (s_rd || s_wr))
        |=> drive_task_regs_sel && !drive_aux_regs_sel)
        else $error("double hit did not give task select");
    sel_needs_strobe_a: assert property (@(posedge clk) disable iff (rst)
        (drive_task_regs_sel || drive_aux_regs_sel) |-> $past(hit && (s_rd || s_wr)))
        else $error("select without a decoded access");

    // bit 7 steering: two drivers on one wire would fight on the board
    write_wins_a: assert property (@(posedge clk) disable iff (rst)
        (s_wr && s_rd && hit) |=> drive_bit7_io_oe && !host_data_bit7_oe)
        else $error("both strobes did not favour the write");
    one_driver_a: assert property (@(posedge clk) disable iff (rst)
        !(drive_bit7_io_oe && host_data_bit7_oe))
        else $error("both bit 7 drivers on");
    drive_mode_a: assert property (@(posedge clk) disable iff (rst)
        drive_bit7_io_oe |-> st_r.mode == IPG_WR)
        else $error("drive bit 7 driven outside a write");
    read_input_a: assert property (@(posedge clk) disable iff (rst)
        (s_rd && !s_wr && hit) |=> !drive_bit7_io_oe && host_data_bit7_oe)
        else $error("read left drive bit 7 driven");
    host_mode_a: assert property (@(posedge clk) disable iff (rst)
        host_data_bit7_oe |-> st_r.mode inside {IPG_RD, IPG_RD_FLOPPY_DISK_CHANGED_N})
        else $error("host bit 7 driven outside a read");
    floppy_disk_changed_n_host_oe_a: assert property (@(posedge clk) disable iff (rst)
        (s_rd && !s_wr && hit && addr_s2 == IPG_FLOPPY_DISK_CHANGED_N_ADDR)
        |=> host_data_bit7_oe && !drive_bit7_io_oe)
        else $error("3F7 read did not drive host bit 7");

    // quiet when nothing is decoded, and straight out of reset
    host_idle_a: assert property (@(posedge clk) disable iff (rst)
        !(hit && s_rd && !s_wr) |=> !host_data_bit7_oe)
        else $error("host bit 7 driven with no read");
    reset_idle_a: assert property (@(posedge clk)
        rst |=> lo_byte_xcvr_en_n && hi_byte_xcvr_en_n && !drive_task_regs_sel
        && !drive_aux_regs_sel && !drive_bit7_io_oe && !host_data_bit7_oe)
        else $error("outputs active after reset");

    wide_cov: cover property (@(posedge clk) !hi_byte_xcvr_en_n);
    aux_cov: cover property (@(posedge clk) drive_aux_regs_sel);
    floppy_disk_changed_n_cov: cover property (@(posedge clk) st_r.mode == IPG_RD_FLOPPY_DISK_CHANGED_N);
    wr_cov: cover property (@(posedge clk) drive_bit7_io_oe);
    rd_cov: cover property (@(posedge clk) st_r.mode == IPG_RD);
endmodule

// [rtl/ipg_pkg.sv]
/*
 Package for the drive-port glue: access kinds, state layout, decode constants.
 Assumes a single 40 MHz clock domain and a synchronous active-high reset.
*/
package ipg_pkg;
    localparam logic [9:0] IPG_FLOPPY_DISK_CHANGED_N_ADDR = 10'h3F7;
    localparam int IPG_SYNC_STAGES = 2;

    typedef enum logic [1:0] {
        IPG_IDLE = 2'h0,
        IPG_WR = 2'h1,
        IPG_RD = 2'h3,
        IPG_RD_FLOPPY_DISK_CHANGED_N = 2'h2
    } ipg_mode_t;

    typedef struct packed {
        ipg_mode_t mode;
        logic hi_en_n;
        logic lo_en_n;
        logic task_sel;
        logic aux_sel;
        logic d7_oe;
        logic d7_out;
        logic host_d7;
        logic host_d7_oe;
        logic [9:0] addr_meta;
        logic [9:0] addr_sync;
    } ipg_state_t;
endpackage

// [rtl/ipg_sync_if.sv]
/*
 Interface carrying the synchronised pin levels from the input stage to the core.
 Assumes both modules sit on the same clock.
*/
`timescale 1ns/10ps
interface ipg_sync_if;
    logic [7:0] bits;
    modport src (output bits);
    modport dst (input bits);
endinterface

// [rtl/ipg_sync.sv]
/*
 Two-flop synchroniser for the single-bit asynchronous pin inputs of the glue block; the address is staged in the glue itself.
 Assumes clk is the block clock; the first stage is read only by the second.
*/
`timescale 1ns/10ps
module ipg_sync (
    input wire logic clk,
    input wire logic rst,
    input wire logic [7:0] raw,
    ipg_sync_if.src out
);
    import ipg_pkg::*;

    typedef struct packed {
        logic [7:0] meta;
        logic [7:0] stable;
    } ipg_sync_st_t;

    ipg_sync_st_t s_r;
    ipg_sync_st_t s_nxt;

    always_comb begin
        s_nxt.meta = raw;
        s_nxt.stable = s_r.meta;
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign out.bits = s_r.stable;
endmodule

// [test/ipg_drive_model.sv]
/*
 Far-side drive model for the bit 7 data line.
 Assumes the bench tells it when the drive answers a read.
*/
`timescale 1ns/10ps
module ipg_drive_model (
    input wire logic clk,
    input wire logic dut_oe,
    input wire logic dut_out,
    input wire logic rd_act,
    input wire logic drv_val,
    output logic bit7_lvl
);
    logic last_r = 1'b0;
    // released line shows the inverse, so a stale value never passes
    assign bit7_lvl = dut_oe ? dut_out : (rd_act ? drv_val : ~last_r);
    always @(posedge clk) begin
        last_r <= bit7_lvl;
    end
endmodule

// [test/ide_port_glue_logic_bench.sv]
/*
 Self-checking bench for the drive-port glue.
 Assumes outputs settle within three edges of an input change.
*/
`timescale 1ns/10ps
module ide_port_glue_logic_bench;
    logic clk = 0, rst = 1, th = 0, ah = 0, w16 = 0, ior_n = 1, iow_n = 1;
    logic hb = 0, db = 0, dc = 1, hi_n, lo_n, ts, ax, d_oe, d_out, h_oe, h_out, d_lvl;
    logic [9:0] ad = 10'h000;
    int errors = 0, check_count = 0;
    always #12.5 clk = ~clk;
    ipg_drive_model drv_u (.clk(clk), .dut_oe(d_oe), .dut_out(d_out), .rd_act(~ior_n),
        .drv_val(db), .bit7_lvl(d_lvl));
    ipg_glue dut_u (.clk(clk), .rst(rst), .decode_task_hit(th), .decode_aux_hit(ah),
        .xfer_16bit(w16), .ior_n(ior_n), .iow_n(iow_n), .host_addr(ad),
        .host_data_bit7_in(h_oe ? h_out : hb), .drive_bit7_io_in(d_lvl),
        .floppy_disk_changed_n(dc), .hi_byte_xcvr_en_n(hi_n), .lo_byte_xcvr_en_n(lo_n),
        .drive_task_regs_sel(ts), .drive_aux_regs_sel(ax), .drive_bit7_io_out(d_out),
        .drive_bit7_io_oe(d_oe), .host_data_bit7_out(h_out), .host_data_bit7_oe(h_oe));
    task automatic wrap_up;
        $display("errors=%0d checks=%0d", errors, check_count);
        if (errors == 0 && check_count > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    // levels of one access; sync chain plus output flop need three edges, four are given
    task automatic apply(input logic t, a, w, r, wr, input logic [9:0] adr,
            input logic h, d, c);
        @(posedge clk);
        th <= t;
        ah <= a;
        w16 <= w;
        ior_n <= ~r;
        iow_n <= ~wr;
        ad <= adr;
        hb <= h;
        db <= d;
        dc <= c;
        repeat (4) @(posedge clk);
        #1;
    endtask
    // data values only count while their enable is up
    task automatic check(input logic [7:0] exp);
        logic [7:0] got;
        got = {hi_n, lo_n, ts, ax, d_oe, d_oe & d_out, h_oe, h_oe & h_out};
        check_count++;
        if (got !== exp) begin
            errors++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic idle_bus;
        @(posedge clk);
        th <= 0;
        ah <= 0;
        w16 <= 0;
        ior_n <= 1;
        iow_n <= 1;
        repeat (4) @(posedge clk);
    endtask
    task automatic no_access_scn;
        apply(0, 0, 0, 0, 0, 10'h1F7, 1, 1, 1);
        check(8'hC0);
        apply(0, 0, 1, 1, 0, 10'h1F0, 1, 1, 1);
        check(8'hC0);
        apply(1, 1, 0, 0, 0, 10'h1F0, 1, 1, 1);
        check(8'hC0);
        idle_bus();
    endtask
    task automatic task_write_scn;
        apply(1, 0, 1, 0, 1, 10'h1F0, 1, 0, 1);
        check(8'h2C);
        apply(1, 0, 1, 0, 1, 10'h1F0, 0, 1, 1);
        check(8'h28);
        idle_bus();
    endtask
    task automatic aux_write_scn;
        apply(0, 1, 0, 0, 1, 10'h3F6, 1, 0, 1);
        check(8'h9C);
        apply(0, 1, 0, 0, 1, 10'h3F7, 1, 0, 0);
        check(8'h9C);
        idle_bus();
    endtask
    task automatic task_read_scn;
        apply(1, 0, 0, 1, 0, 10'h1F7, 0, 1, 1);
        check(8'hA3);
        apply(1, 0, 0, 1, 0, 10'h1F7, 1, 0, 1);
        check(8'hA2);
        apply(1, 0, 1, 1, 0, 10'h1F0, 0, 1, 1);
        check(8'h23);
        idle_bus();
    endtask
    task automatic floppy_disk_changed_n_read_scn;
        apply(0, 1, 0, 1, 0, 10'h3F7, 1, 1, 0);
        check(8'h92);
        apply(0, 1, 0, 1, 0, 10'h3F7, 0, 0, 1);
        check(8'h93);
        apply(1, 0, 0, 1, 0, 10'h3F7, 1, 1, 0);
        check(8'hA2);
        idle_bus();
    endtask
    // double hit goes to the task registers; both strobes count as a write
    task automatic conflict_scn;
        apply(1, 1, 0, 0, 1, 10'h1F0, 1, 0, 1);
        check(8'hAC);
        apply(1, 0, 1, 1, 1, 10'h1F0, 1, 0, 1);
        check(8'h2C);
        idle_bus();
    endtask
    // reset in the middle of a held access, then the access comes back after release
    task automatic reset_scn;
        apply(1, 0, 1, 0, 1, 10'h1F0, 1, 0, 1);
        check(8'h2C);
        @(posedge clk);
        rst <= 1;
        @(posedge clk);
        #1;
        check(8'hC0);
        repeat (3) @(posedge clk);
        rst <= 0;
        @(posedge clk);
        #1;
        check(8'hC0);
        repeat (2) @(posedge clk);
        #1;
        check(8'h2C);
        idle_bus();
    endtask
    initial begin
        repeat (4) @(posedge clk);
        rst <= 0;
        repeat (3) @(posedge clk);
        no_access_scn();
        task_write_scn();
        aux_write_scn();
        task_read_scn();
        floppy_disk_changed_n_read_scn();
        conflict_scn();
        reset_scn();
        wrap_up();
    end
    initial begin
        #20000;
        errors++;
        wrap_up();
    end
endmodule
